// file: hw/mdfm_defs.vh
`ifndef MDFM_DEFS_VH
`define MDFM_DEFS_VH
// Action select encodings shared by overcurrent and stall handling
`define MDFM_ACT_LATCH   2'h0
`define MDFM_ACT_RETRY   2'h1
`define MDFM_ACT_REPORT  2'h2
`define MDFM_ACT_NONE    2'h3
// Overvoltage level select: 0 = lower level, 1 = higher level
`define MDFM_OV_LOW      1'h0
`define MDFM_OV_HIGH     1'h1
// Retry times as cycles at 50 MHz, sized to the timer width so no bits drop
// Overcurrent 5 ms, buck 1 ms, stall 5 ms; shorten here for faster runs
`define MDFM_RETRY_CYC        24'h03D090
`define MDFM_BK_RETRY_CYC     24'h00C350
`define MDFM_LOCK_RETRY_CYC   24'h03D090
`define MDFM_CNT_W            24
// Status word bit positions
`define MDFM_ST_FAULT    0
`define MDFM_ST_POR      1
`define MDFM_ST_RGF      2
`define MDFM_ST_RGUV     3
`define MDFM_ST_PUV      4
`define MDFM_ST_OV       5
`define MDFM_ST_OC       6
`define MDFM_ST_RGOC     7
`define MDFM_ST_SER      8
`define MDFM_ST_FUSE     9
`define MDFM_ST_STALL    10
`define MDFM_ST_OTW      11
`define MDFM_ST_OTS      12
`define MDFM_ST_W        13
`endif

// file: hw/mdfm_fault_manager.v
`include "mdfm_defs.vh"
module mdfm_fault_manager (
  input  wire                   clk,                       // 50 MHz system clock
  input  wire                   rst_n,                     // Async reset, active low
  input  wire                   ce,                        // Clock enable, freezes state low
  input  wire                   supply_uv,                 // Main supply below lockout
  input  wire                   analog_reg_uv,             // Analog regulator undervoltage
  input  wire                   regulator_uv,              // Buck regulator undervoltage
  input  wire                   pump_undervolt_cond,       // Charge pump undervoltage
  input  wire                   overvolt_low_cmp,          // Supply above lower level
  input  wire                   overvolt_high_cmp,         // Supply above higher level
  input  wire                   overcurrent,               // Phase overcurrent event
  input  wire                   regulator_overcurrent,     // Buck overcurrent event
  input  wire                   serial_error,              // Serial clock/address error
  input  wire                   fuse_error,                // Fuse read error
  input  wire                   stall,                     // No Hall edges in detect time
  input  wire                   overtemp_warn,             // Over-temperature warning level
  input  wire                   overtemp_shutdown,         // Die or switch shutdown level
  input  wire                   pin_config,                // Pin-configured variant
  input  wire                   overvolt_enable,           // Overvoltage protection enable
  input  wire                   overvolt_level_select,     // Threshold select
  input  wire [1:0]             overcurrent_action_select, // Overcurrent action mode
  input  wire [1:0]             stall_action_select,       // Stall action mode
  input  wire                   serial_error_report_mask,  // 1 = serial error kept off fault pin, flag still sets
  input  wire                   overtemp_warn_report,      // 1 = warning on fault pin
  input  wire                   clear_faults_cmd,          // Clear-faults pulse
  input  wire                   sleep_pin_n,               // Sleep pin, low pulse resets
  output reg                    fault_out_n,               // Fault output, active low
  output reg                    gate_hiz,                  // All switches Hi-Z
  output reg                    pump_disable,              // Charge pump off
  output reg                    logic_disable,             // Logic controller held off
  output wire [`MDFM_ST_W-1:0]  status_flags,              // Latched flags
  output wire [7:0]             ic_status_reg              // Summary status
);
  localparam ST_RUN   = 2'h0;
  localparam ST_LATCH = 2'h1;
  localparam ST_RETRY = 2'h2;

  reg  [1:0] oc_state_reg;
  reg  [1:0] oc_state_next;
  reg  [1:0] sl_state_reg;
  reg  [1:0] sl_state_next;
  reg        sleep_d_reg;
  reg        fuse_lat_reg;
  reg        ser_act_reg;
  reg        sl_rep_reg;
  reg        fault_flag;
  reg        power_on_reset_flag;
  reg        regulator_fault_flag;
  reg        regulator_undervolt_flag;
  reg        pump_undervolt_flag;
  reg        overvolt_flag;
  reg        overcurrent_flag;
  reg        regulator_overcurrent_flag;
  reg        serial_error_flag;
  reg        fuse_flag;
  reg        stall_flag;
  reg        overtemp_warn_flag;
  reg        overtemp_shutdown_flag;
  reg        lockout_d_reg;
  reg        bk_hold_reg;

  wire       oc_busy;
  wire       oc_done;
  wire       sl_busy;
  wire       sl_done;
  wire       bk_busy;
  wire       bk_done;

  // Sleep pin rising edge ends a reset pulse; it clears like the command
  wire sleep_pulse = sleep_pin_n && !sleep_d_reg;
  wire clr = clear_faults_cmd || sleep_pulse;
  wire lockout = supply_uv || analog_reg_uv;

  // Threshold choice; pin parts force enable and the higher level
  wire ov_en  = pin_config || overvolt_enable;
  wire ov_sel = pin_config ? `MDFM_OV_HIGH : overvolt_level_select;
  wire ov_hit = ov_en && ((ov_sel == `MDFM_OV_HIGH) ? overvolt_high_cmp
                                                    : overvolt_low_cmp);

  // Pin parts always latch on overcurrent and stall
  wire [1:0] oc_mode = pin_config ? `MDFM_ACT_LATCH : overcurrent_action_select;
  wire [1:0] sl_mode = pin_config ? `MDFM_ACT_LATCH : stall_action_select;

  // Takes a mode and reports whether it reacts at all
  function acts;
    input [1:0] m;
    begin
      acts = (m != `MDFM_ACT_NONE);
    end
  endfunction

  wire oc_evt = overcurrent && (oc_mode == `MDFM_ACT_LATCH || oc_mode == `MDFM_ACT_RETRY);
  wire sl_evt = stall && acts(sl_mode);

  // Overcurrent response: latch waits for a clear with condition gone
  always @*
  begin
    oc_state_next = oc_state_reg;
    case (oc_state_reg)
      ST_RUN:
        if (oc_evt)
          oc_state_next = (oc_mode == `MDFM_ACT_RETRY) ? ST_RETRY : ST_LATCH;
      ST_LATCH:
        if (clr && !overcurrent)
          oc_state_next = ST_RUN;
      ST_RETRY:
        if (oc_done)
          oc_state_next = ST_RUN;
      default:
        oc_state_next = ST_RUN;
    endcase
  end

  // Stall response; report mode does not stop drive
  always @*
  begin
    sl_state_next = sl_state_reg;
    case (sl_state_reg)
      ST_RUN:
        if (sl_evt && sl_mode == `MDFM_ACT_LATCH)
          sl_state_next = ST_LATCH;
        else if (sl_evt && sl_mode == `MDFM_ACT_RETRY)
          sl_state_next = ST_RETRY;
      ST_LATCH:
        if (clr)
          sl_state_next = ST_RUN;
      ST_RETRY:
        if (sl_done)
          sl_state_next = ST_RUN;
      default:
        sl_state_next = ST_RUN;
    endcase
  end

  mdfm_retry_timer #(
    .LOAD (`MDFM_RETRY_CYC)
  ) u_oc_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (oc_state_reg == ST_RUN && oc_state_next == ST_RETRY),
    .busy  (oc_busy),
    .done  (oc_done)
  );

  mdfm_retry_timer #(
    .LOAD (`MDFM_LOCK_RETRY_CYC)
  ) u_sl_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (sl_state_reg == ST_RUN && sl_state_next == ST_RETRY),
    .busy  (sl_busy),
    .done  (sl_done)
  );

  // Buck overcurrent holds the fault for the buck retry time
  mdfm_retry_timer #(
    .LOAD (`MDFM_BK_RETRY_CYC)
  ) u_bk_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (regulator_overcurrent && !bk_hold_reg),
    .busy  (bk_busy),
    .done  (bk_done)
  );

  // State registers and response latches
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_state_reg  <= ST_RUN;
      sl_state_reg  <= ST_RUN;
      sleep_d_reg   <= 1'b1;
      fuse_lat_reg  <= 1'b0;
      ser_act_reg   <= 1'b0;
      sl_rep_reg    <= 1'b0;
      lockout_d_reg <= 1'b0;
      bk_hold_reg   <= 1'b0;
    end
    else if (ce)
    begin
      oc_state_reg  <= oc_state_next;
      sl_state_reg  <= sl_state_next;
      sleep_d_reg   <= sleep_pin_n;
      lockout_d_reg <= lockout;
      // Fuse error ignores the command; only a sleep pulse releases it
      fuse_lat_reg  <= fuse_error || (fuse_lat_reg && !sleep_pulse);
      // Set wins over clear for reported latched conditions
      ser_act_reg   <= (serial_error && !serial_error_report_mask)
                       || (ser_act_reg && !clr);
      sl_rep_reg    <= (stall && sl_mode == `MDFM_ACT_REPORT)
                       || (sl_rep_reg && !clr);
      if (regulator_overcurrent && !bk_hold_reg)
        bk_hold_reg <= 1'b1;
      else if (bk_done)
        bk_hold_reg <= 1'b0;
    end
  end

  // Conditions that currently pull the fault output low
  wire fault_any = regulator_uv
                   || pump_undervolt_cond
                   || ov_hit
                   || (oc_state_reg != ST_RUN)
                   || bk_hold_reg || regulator_overcurrent
                   || ser_act_reg
                   || fuse_lat_reg || fuse_error
                   || (sl_state_reg != ST_RUN) || sl_rep_reg
                   || (overtemp_warn && overtemp_warn_report)
                   || overtemp_shutdown;

  // Sticky flags: set on event, clear on command, set wins; POR, fuse and buck overcurrent differ
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_flag                 <= 1'b0;
      power_on_reset_flag        <= 1'b0;
      regulator_fault_flag       <= 1'b0;
      regulator_undervolt_flag   <= 1'b0;
      pump_undervolt_flag        <= 1'b0;
      overvolt_flag              <= 1'b0;
      overcurrent_flag           <= 1'b0;
      regulator_overcurrent_flag <= 1'b0;
      serial_error_flag          <= 1'b0;
      fuse_flag                  <= 1'b0;
      stall_flag                 <= 1'b0;
      overtemp_warn_flag         <= 1'b0;
      overtemp_shutdown_flag     <= 1'b0;
    end
    else if (ce)
    begin
      // Low after lockout recovery, goes high only on a clear
      if (lockout || lockout_d_reg)
        power_on_reset_flag <= 1'b0;
      else if (clr)
        power_on_reset_flag <= 1'b1;
      fault_flag <= fault_any || (fault_flag && !clr);
      regulator_fault_flag <= regulator_uv || regulator_overcurrent
                              || (regulator_fault_flag && !clr);
      regulator_undervolt_flag <= regulator_uv
                                  || (regulator_undervolt_flag && !clr);
      pump_undervolt_flag <= pump_undervolt_cond
                             || (pump_undervolt_flag && !clr);
      overvolt_flag <= ov_hit || (overvolt_flag && !clr);
      overcurrent_flag <= oc_evt || (overcurrent_flag && !clr);
      // Buck overcurrent flag lasts only the retry period
      regulator_overcurrent_flag <= regulator_overcurrent
                                    || (regulator_overcurrent_flag && !bk_done);
      serial_error_flag <= serial_error || (serial_error_flag && !clr);
      fuse_flag <= fuse_error || (fuse_flag && !sleep_pulse);
      stall_flag <= sl_evt || (stall_flag && !clr);
      // Warning flag also needs the warning gone before it clears
      overtemp_warn_flag <= overtemp_warn
                            || (overtemp_warn_flag && !clr);
      overtemp_shutdown_flag <= overtemp_shutdown
                                || (overtemp_shutdown_flag && !clr);
    end
  end

  // Switch state; buck faults, serial error and warnings leave drive on
  wire hiz_any = lockout
                 || pump_undervolt_cond
                 || ov_hit
                 || (oc_state_reg != ST_RUN)
                 || fuse_lat_reg || fuse_error
                 || (sl_state_reg == ST_LATCH) || (sl_state_reg == ST_RETRY)
                 || overtemp_shutdown;

  // Outputs registered; lockout asserts no fault output, only disables
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_out_n   <= 1'b1;
      gate_hiz      <= 1'b1;
      pump_disable  <= 1'b1;
      logic_disable <= 1'b1;
    end
    else if (ce)
    begin
      fault_out_n   <= !fault_any;
      gate_hiz      <= hiz_any;
      pump_disable  <= lockout || overtemp_shutdown;
      logic_disable <= lockout;
    end
  end

  assign status_flags = {overtemp_shutdown_flag, overtemp_warn_flag, stall_flag, fuse_flag,
                         serial_error_flag, regulator_overcurrent_flag, overcurrent_flag,
                         overvolt_flag, pump_undervolt_flag, regulator_undervolt_flag,
                         regulator_fault_flag, power_on_reset_flag, fault_flag};

  // Summary: fault, power-on, buck, thermal, timers busy
  assign ic_status_reg = {oc_busy, sl_busy, bk_busy, 1'b0,
                          overtemp_warn_flag || overtemp_shutdown_flag,
                          regulator_fault_flag, power_on_reset_flag, fault_flag};
endmodule // mdfm_fault_manager

// file: hw/mdfm_retry_timer.v
`include "mdfm_defs.vh"
// Retry timer: loads on start, counts down, pulses done at zero
module mdfm_retry_timer #(
  parameter [`MDFM_CNT_W-1:0] LOAD = 24'h000001
) (
  input  wire clk,      // System clock
  input  wire rst_n,    // Async reset, active low
  input  wire ce,       // Clock enable
  input  wire start,    // Begin a retry wait
  output wire busy,     // Wait in progress
  output wire done      // One-cycle pulse at expiry
);
  reg [`MDFM_CNT_W-1:0] cnt_reg;

  // Start during a wait restarts the wait
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= {`MDFM_CNT_W{1'b0}};
    else if (ce)
    begin
      if (start)
        cnt_reg <= LOAD;
      else if (cnt_reg != {`MDFM_CNT_W{1'b0}})
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign busy = (cnt_reg != {`MDFM_CNT_W{1'b0}});
  assign done = ce && !start && (cnt_reg == {{(`MDFM_CNT_W-1){1'b0}}, 1'b1});
endmodule // mdfm_retry_timer

// file: verification/mdfm_ctrl_model.sv
// External controller: issues clear commands and sleep reset pulses on request
module mdfm_ctrl_model #(
  parameter int SLEEP_LOW = 4
) (
  input  wire logic clk,              // System clock
  input  wire logic rst_n,            // Async reset, active low
  input  wire logic do_clear,         // Request a clear command
  input  wire logic do_sleep,         // Request a sleep reset pulse
  output logic      clear_faults_cmd, // One-cycle clear pulse
  output logic      sleep_pin_n       // Sleep pin, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Sleep pulse stays low for SLEEP_LOW cycles so the rising edge is clean
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clear_faults_cmd <= 1'b0;
      sleep_pin_n      <= 1'b1;
      cnt              <= 0;
    end
    else
    begin
      clear_faults_cmd <= do_clear;
      cnt              <= do_sleep ? SLEEP_LOW : (cnt != 0 ? cnt - 1 : 0);
      sleep_pin_n      <= !(do_sleep || cnt > 1);
    end
  end
endmodule // mdfm_ctrl_model

// file: verification/mdfm_fault_manager_asserts.sv
`include "mdfm_defs.vh"
// Port-level checks on the fault manager; direct conditions show one cycle after their
// cause, responses held in state registers (serial report, stall) one cycle later
module mdfm_fault_manager_asserts (
  input wire logic                  clk, rst_n, ce, supply_uv, analog_reg_uv, regulator_uv,
  input wire logic                  pump_undervolt_cond, overvolt_low_cmp, overvolt_high_cmp,
  input wire logic                  overcurrent, regulator_overcurrent, serial_error,
  input wire logic                  fuse_error, stall, overtemp_warn, overtemp_shutdown,
  input wire logic                  pin_config, overvolt_enable, overvolt_level_select,
  input wire logic [1:0]            overcurrent_action_select, stall_action_select,
  input wire logic                  serial_error_report_mask, overtemp_warn_report,
  input wire logic                  clear_faults_cmd, sleep_pin_n,
  input wire logic                  fault_out_n, gate_hiz, pump_disable, logic_disable,
  input wire logic [`MDFM_ST_W-1:0] status_flags, // Latched flags
  input wire logic [7:0]            ic_status_reg  // Summary status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Latched overcurrent trip, then three quiet cycles with no clear of any kind
  sequence oc_latched_trip;
    ce && overcurrent && overcurrent_action_select == 2'h0 && sleep_pin_n;
  endsequence
  sequence no_clear_run;
    (!clear_faults_cmd && sleep_pin_n) [*3];
  endsequence

  lockout_off_a: assert property (
    ce && (supply_uv || analog_reg_uv) |=> gate_hiz && pump_disable && logic_disable)
    else $error("lockout left a stage enabled");
  por_low_a: assert property (
    ce && supply_uv |=> !status_flags[`MDFM_ST_POR])
    else $error("power-on flag not low in lockout");
  regulator_undervolt_flag_a: assert property (
    ce && regulator_uv |=> !fault_out_n && status_flags[`MDFM_ST_RGF]
      && status_flags[`MDFM_ST_RGUV] && ic_status_reg[2])
    else $error("buck undervoltage not reported");
  pump_uv_a: assert property (
    ce && pump_undervolt_cond |=> gate_hiz && !fault_out_n && status_flags[`MDFM_ST_PUV])
    else $error("pump undervoltage response wrong");
  ov_trip_a: assert property (
    ce && (pin_config ? overvolt_high_cmp : overvolt_enable
      && (overvolt_level_select ? overvolt_high_cmp : overvolt_low_cmp))
      |=> gate_hiz && !fault_out_n)
    else $error("overvoltage not acted on");
  oc_latch_a: assert property (
    oc_latched_trip ##1 no_clear_run |=> gate_hiz)
    else $error("latched overcurrent released without clear");
  rgoc_fault_a: assert property (
    ce && regulator_overcurrent |=> !fault_out_n && status_flags[`MDFM_ST_RGOC])
    else $error("buck overcurrent not reported");
  serial_rep_a: assert property (
    ce && serial_error && !serial_error_report_mask
      |=> status_flags[`MDFM_ST_SER] ##1 !fault_out_n)
    else $error("serial error not reported");
  fuse_hiz_a: assert property (
    ce && fuse_error |=> gate_hiz && !fault_out_n)
    else $error("fuse error response wrong");
  stall_rep_a: assert property (
    ce && stall && stall_action_select != 2'h3 |=> ##1 !fault_out_n)
    else $error("stall not reported");
  overtemp_warn_report_a: assert property (
    ce && overtemp_warn && overtemp_warn_report |=> !fault_out_n && ic_status_reg[3])
    else $error("reported warning missing");
  ots_hiz_a: assert property (
    ce && overtemp_shutdown |=> gate_hiz && !fault_out_n && status_flags[`MDFM_ST_OTS])
    else $error("thermal shutdown response wrong");
endmodule // mdfm_fault_manager_asserts

bind mdfm_fault_manager mdfm_fault_manager_asserts u_mdfm_fault_manager_asserts (.*);

// file: verification/mdfm_fault_manager_test.sv
`include "mdfm_defs.vh"
module mdfm_fault_manager_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLEEP_LOW  = 4;
  localparam int MAX_CYCLES = 80000; // Buck retry wait dominates the run
  logic        clk, rst_n, ce, pin_config, overvolt_enable, overvolt_level_select;
  logic        serial_error_report_mask, overtemp_warn_report, do_clear, do_sleep;
  logic [1:0]  overcurrent_action_select, stall_action_select;
  logic [12:0] cond;
  wire         supply_uv, analog_reg_uv, regulator_uv, pump_undervolt_cond, overvolt_low_cmp;
  wire         overvolt_high_cmp, overcurrent, regulator_overcurrent, serial_error, fuse_error;
  wire         stall, overtemp_warn, overtemp_shutdown, clear_faults_cmd, sleep_pin_n;
  wire         fault_out_n, gate_hiz, pump_disable, logic_disable;
  wire [`MDFM_ST_W-1:0] status_flags;
  wire [7:0]   ic_status_reg;
  int          miscompares, n_compared, cycles;

  // Condition vector; from bit 6 upward the index equals the flag position
  assign {overtemp_shutdown, overtemp_warn, stall, fuse_error, serial_error,
          regulator_overcurrent, overcurrent, overvolt_high_cmp, overvolt_low_cmp,
          pump_undervolt_cond, regulator_uv, analog_reg_uv, supply_uv} = cond;

  mdfm_fault_manager u_mdfm_fault_manager (.*);
  mdfm_ctrl_model #(.SLEEP_LOW(SLEEP_LOW)) u_mdfm_ctrl_model (.*);

  always #10 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES)
    begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  task automatic see(int n); repeat (n) @(posedge clk); @(negedge clk); endtask
  task automatic set(int i, logic v); @(posedge clk); cond[i] <= v; endtask
  task automatic trip(int i); set(i, 1'b1); see(3); endtask
  task automatic calm(int i); set(i, 1'b0); see(3); endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clr(); @(posedge clk); do_clear <= 1'b1; @(posedge clk); do_clear <= 1'b0; see(4);
  endtask
  task automatic slp(); @(posedge clk); do_sleep <= 1'b1; @(posedge clk); do_sleep <= 1'b0;
    see(SLEEP_LOW + 4);
  endtask
  // Reset ends every retry timer, so long retry waits need not be sat out
  task automatic do_reset(int n); @(posedge clk); rst_n <= 1'b0; repeat (n) @(posedge clk);
    rst_n <= 1'b1; see(2); clr();
  endtask

  task automatic t_lockout();
    for (int i = 0; i < 2; i++)
    begin
      trip(i);
      chk("lock_off", {gate_hiz, pump_disable, logic_disable}, 3'h7);
      chk("lock_por", status_flags[1], 1'h0);
      calm(i);
      chk("lock_run", {gate_hiz, pump_disable, logic_disable}, 3'h0);
      chk("por_held", status_flags[1], 1'h0);
      clr();
      chk("por_set", status_flags[1], 1'h1);
    end
  endtask

  task automatic t_undervolt();
    trip(2);
    chk("buck_on", {fault_out_n, status_flags[3:2], status_flags[0], gate_hiz}, 5'h0E);
    calm(2);
    chk("buck_off", {fault_out_n, status_flags[3:2]}, 3'h7);
    slp();
    chk("buck_clr", status_flags[3:2], 2'h0);
    trip(3);
    chk("pump_on", {gate_hiz, fault_out_n, status_flags[4]}, 3'h5);
    calm(3);
    chk("pump_off", {gate_hiz, fault_out_n, status_flags[4]}, 3'h3);
    clr();
    chk("pump_clr", status_flags[4], 1'h0);
  endtask

  task automatic t_overvolt();
    logic exp;
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clk);
      {pin_config, overvolt_enable, overvolt_level_select} <= k[3:1];
      cond[4] <= 1'b1;
      cond[5] <= k[0];
      see(3);
      exp = k[0] ? (k[3] || k[2]) : (!k[3] && k[2] && !k[1]);
      chk("ov_hiz", gate_hiz, exp);
      chk("ov_fault", fault_out_n, !exp);
      @(posedge clk);
      cond[5:4] <= 2'h0;
      see(3);
      chk("ov_run", {gate_hiz, fault_out_n, status_flags[5]}, {2'h1, exp});
      clr();
    end
    @(posedge clk);
    pin_config <= 1'b0;
  endtask

  task automatic t_overcurrent();
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      overcurrent_action_select <= m[1:0];
      trip(6);
      chk("oc_trip", {gate_hiz, fault_out_n, status_flags[6], status_flags[0]}, 4'hB);
      calm(6);
      see(20);
      chk("oc_held", {gate_hiz, status_flags[6], status_flags[0]}, 3'h7);
      chk("oc_busy", ic_status_reg[7], m[0]);
      if (m == 0) clr();
      else do_reset(2);
      chk("oc_clr", {gate_hiz, fault_out_n, status_flags[6]}, 3'h2);
    end
  endtask

  task automatic t_serial_fuse();
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      serial_error_report_mask <= m[0];
      trip(8);
      calm(8);
      see(5);
      chk("ser_rep", {gate_hiz, fault_out_n}, {1'h0, m[0]});
      clr();
      chk("ser_clr", fault_out_n, 1'h1);
    end
    trip(9);
    calm(9);
    clr();
    chk("fuse_hold", {gate_hiz, fault_out_n}, 2'h2);
    slp();
    chk("fuse_slp", {gate_hiz, fault_out_n}, 2'h1);
  endtask

  task automatic t_stall();
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      stall_action_select <= m[1:0];
      trip(10);
      calm(10);
      chk("stall_act", {gate_hiz, fault_out_n}, {m < 2, m == 3});
      if (m == 1) do_reset(2);
      else clr();
      chk("stall_clr", {gate_hiz, fault_out_n}, 2'h1);
    end
  endtask

  task automatic t_thermal();
    for (int r = 0; r < 2; r++)
    begin
      @(posedge clk);
      overtemp_warn_report <= r[0];
      trip(11);
      chk("overtemp_warn_report", {gate_hiz, fault_out_n}, {1'h0, !r[0]});
      calm(11);
      chk("otw_off", fault_out_n, 1'h1);
      clr();
    end
    trip(12);
    chk("ots_on", {gate_hiz, fault_out_n, status_flags[12]}, 3'h5);
    chk("ots_stat", {pump_disable, ic_status_reg[3]}, 2'h3);
    trip(11);
    calm(12);
    chk("or_hold", {gate_hiz, fault_out_n}, 2'h0);
    calm(11);
    chk("ots_off", {gate_hiz, fault_out_n, status_flags[12]}, 3'h3);
    clr();
    chk("ots_clr", status_flags[12], 1'h0);
  endtask

  task automatic t_buck_oc();
    int k;
    trip(7);
    calm(7);
    chk("rgoc_on", {fault_out_n, gate_hiz, status_flags[7]}, 3'h1);
    for (k = 0; k < 60000 && fault_out_n !== 1'b1; k++) @(negedge clk);
    chk("rgoc_rel", fault_out_n, 1'h1);
    chk("rgoc_time", k >= `MDFM_BK_RETRY_CYC - 10, 1'h1);
  endtask

  task summarize;
    $display("miscompares %0d n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0; rst_n = 1'b0; ce = 1'b1; cond = '0; pin_config = 1'b0;
    overvolt_enable = 1'b0; overvolt_level_select = 1'b0; serial_error_report_mask = 1'b0;
    overtemp_warn_report = 1'b0; overcurrent_action_select = 2'h0; stall_action_select = 2'h0;
    do_clear = 1'b0; do_sleep = 1'b0; miscompares = 0; n_compared = 0; cycles = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    see(2);
    clr();
    t_lockout();
    t_undervolt();
    t_overvolt();
    t_overcurrent();
    t_serial_fuse();
    t_stall();
    t_thermal();
    t_buck_oc();
    summarize();
  end
endmodule // mdfm_fault_manager_test
